// *** alu8.sv ***
/*
 * 8-bit arithmetic and logic unit, purely combinational.
 * Assumes the caller registers the result and decides which flags to keep.
 */
`timescale 1ns/100ps
`default_nettype none

module alu8
    import core_pkg::*;
(
    // operation and operands
    input  wire alu_fn_t    fn_in,
    input  wire logic [7:0] acc_in,
    input  wire logic [7:0] opnd_in,
    input  wire flags_t     flags_in,
    // result
    output logic [7:0]      res_out,
    output flags_t          flags_out
);

    logic [7:0] b;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [8:0] dlo;
    logic [8:0] dfull;

    always_comb begin
        b     = (fn_in == FN_SUB || fn_in == FN_SBC) ? ~opnd_in : opnd_in;
        cin   = (fn_in == FN_SUB) | ((fn_in == FN_ADC || fn_in == FN_SBC) & flags_in.c);
        sum   = {1'b0, acc_in} + {1'b0, b} + {8'h00, cin};
        nib   = {1'b0, acc_in[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        // decimal adjust: low digit first, then high digit
        dlo   = {1'b0, acc_in} + ((acc_in[3:0] > 4'h9 || flags_in.ac) ? 9'h006 : 9'h000);
        dfull = dlo + ((dlo[7:4] > 4'h9 || flags_in.c || dlo[8]) ? 9'h060 : 9'h000);
        res_out   = opnd_in;
        flags_out = flags_in;
        case (fn_in)
            FN_ADD, FN_ADC, FN_SUB, FN_SBC: begin
                res_out      = sum[7:0];
                flags_out.c  = sum[8];
                flags_out.ac = nib[4];
                flags_out.ov = (acc_in[7] == b[7]) && (sum[7] != acc_in[7]);
            end
            FN_DAA: begin
                res_out     = dfull[7:0];
                flags_out.c = flags_in.c | dfull[8] | dlo[8] | (dfull[7:4] != dlo[7:4]);
            end
            FN_AND: res_out = acc_in & opnd_in;
            FN_OR:  res_out = acc_in | opnd_in;
            FN_XOR: res_out = acc_in ^ opnd_in;
            FN_CPL: res_out = ~opnd_in;
            FN_RR:  res_out = {opnd_in[0], opnd_in[7:1]};
            FN_RRC: begin
                res_out     = {flags_in.c, opnd_in[7:1]};
                flags_out.c = opnd_in[0];
            end
            FN_RL:  res_out = {opnd_in[6:0], opnd_in[7]};
            FN_RLC: begin
                res_out     = {opnd_in[6:0], flags_in.c};
                flags_out.c = opnd_in[7];
            end
            FN_INC: res_out = opnd_in + 8'h01;
            FN_DEC: res_out = opnd_in - 8'h01;
            default: res_out = opnd_in;
        endcase
        // rotates and moves leave zero alone
        if (fn_in != FN_RR && fn_in != FN_RRC && fn_in != FN_RL && fn_in != FN_RLC && fn_in != FN_PASS) begin
            flags_out.z = (res_out == 8'h00);
        end
    end

endmodule : alu8

`default_nettype wire

// *** core_pkg.sv ***
/*
 * Types shared by the sequencing core and its arithmetic unit.
 * Assumes core_regs.svh is on the include path.
 */
`default_nettype none
`include "core_regs.svh"

package core_pkg;

    // four phases of one instruction cycle, gray coded
    typedef enum logic [1:0] {
        PH_FETCH = 2'b00,
        PH_EX2   = 2'b01,
        PH_EX3   = 2'b11,
        PH_EX4   = 2'b10
    } phase_t;

    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ALU_A = 4'h1,
        OP_ALU_M = 4'h2,
        OP_SKZ_A = 4'h3,
        OP_SKZ_M = 4'h4,
        OP_SKNZ  = 4'h5,
        OP_JMP   = 4'h6,
        OP_CALL  = 4'h7,
        OP_RET   = 4'h8,
        OP_INTERRUPT_EXIT  = 4'h9
    } op_t;

    typedef enum logic [3:0] {
        FN_ADD  = 4'h0,
        FN_ADC  = 4'h1,
        FN_SUB  = 4'h2,
        FN_SBC  = 4'h3,
        FN_DAA  = 4'h4,
        FN_AND  = 4'h5,
        FN_OR   = 4'h6,
        FN_XOR  = 4'h7,
        FN_CPL  = 4'h8,
        FN_RR   = 4'h9,
        FN_RRC  = 4'ha,
        FN_RL   = 4'hb,
        FN_RLC  = 4'hc,
        FN_INC  = 4'hd,
        FN_DEC  = 4'he,
        FN_PASS = 4'hf
    } alu_fn_t;

    // 15-bit program word; arg is a target or {fn, data address}
    typedef struct packed {
        op_t              op;
        logic [`PC_W-1:0] arg;
    } instr_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       we;
    } dmem_req_t;

endpackage : core_pkg

`default_nettype wire

// *** core_regs.svh ***
/*
 * Register offsets, data-memory alias of the program counter low byte,
 * vectors and reset values of the instruction sequencing core.
 * Assumes it is included by bare name before the package is compiled.
 */
`ifndef CORE_REGS_SVH
`define CORE_REGS_SVH

// program counter width: 2K words of program memory
`define PC_W        11

// register port offsets
`define PCL_OFS     4'h0
`define ACC_OFS     4'h1
`define STAT_OFS    4'h2

// data-memory address at which the program counter low byte appears
`define PCL_DADDR   7'h06

// vectors and reset values
`define RESET_VEC   11'h000
`define IRQ_VEC     11'h004
`define ACC_RST     8'h00
`define FLAGS_RST   4'h0

`endif

// *** core_seq.sv ***
/*
 * Instruction sequencing core: four-phase cycle, fetch/execute overlap,
 * program counter, return-address stack, interrupt entry and ALU control.
 * Assumes program memory answers a fetch address one clock later and data
 * memory answers a read address one clock later; both run on clk_in.
 */
// What this block does
// - four non-overlapping phases form one instruction cycle
// - counter advances and fetch happens in fetch phase
// - decode and execute in the execute phases
// - fetch overlaps execute, one instruction per cycle
// - jumps and calls take two instruction cycles
// - counter steps by one unless control transfers
// - 11-bit counter for 2K program words
// - only counter low byte is software reachable
// - jump, call, interrupt, reset load target address
// - taken skip discards prefetch, inserts dummy cycle
// - low byte write jumps within page, dummy cycle
// - stack and level pointer hidden from software
// - call or interrupt acknowledge pushes counter
// - returns pop counter and step pointer back
// - reset empties the stack
// - full stack holds interrupt until a return
// - call on full stack still executes, overflows
// - ALU operation results update flags, skip results do not
// - add, carry add, subtract, borrow, decimal adjust
// - and, or, xor, complement with both destinations
// - rotates, increment, decrement with both destinations
// - branch decisions for jumps, returns and skips
`timescale 1ns/100ps
`default_nettype none
`include "core_regs.svh"

module core_seq
    import core_pkg::*;
#(
    parameter int STACK_DEPTH = 6
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // program memory fetch
    output logic [`PC_W-1:0]      prog_addr_out,
    input  wire instr_t           prog_word_in,
    // data memory
    output dmem_req_t             dmem_req_out,
    input  wire logic [7:0]       dmem_rdata_in,
    // interrupt
    input  wire logic             irq_in,
    input  wire logic             irq_en_in,
    output logic                  irq_ack_out,
    // register port
    input  wire logic [3:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic [7:0]            reg_rdata_out,
    // state
    output logic [3:0]            phase_out,
    output logic                  stack_full_out
);

    localparam int IW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam logic [IW:0]   FULL_LVL = (IW + 1)'(STACK_DEPTH);
    localparam logic [IW-1:0] LAST_IDX = IW'(STACK_DEPTH - 1);

    phase_t           ph_reg;
    phase_t           ph_next;
    logic             end_cyc;
    logic [`PC_W-1:0] pc_reg;
    logic [`PC_W-1:0] pc_next;
    instr_t           cur_reg;
    instr_t           pre_reg;
    logic             cur_valid_reg;
    op_t              cur_op;
    alu_fn_t          cur_fn;
    logic [6:0]       cur_daddr;
    logic             pcl_hit;
    logic             wr_mem;
    logic             wr_acc;
    logic [7:0]       opnd;
    logic [7:0]       alu_res;
    flags_t           alu_flags;
    logic [7:0]       res_reg;
    flags_t           res_flags_reg;
    logic [7:0]       acc_reg;
    flags_t           flags_reg;
    logic             is_jmp;
    logic             is_call;
    logic             is_ret;
    logic             skip_hit;
    logic             pcl_jump;
    logic             redirect;
    logic             take_irq;
    logic             flush;
    logic             push;
    logic             pop;
    logic             irq_flag_reg;
    logic             pcl_pend_reg;
    logic [7:0]       pcl_wdata_reg;
    logic [`PC_W-1:0] stk_mem [STACK_DEPTH];
    logic [IW-1:0]    top_idx_reg;
    logic [IW-1:0]    prev_idx;
    logic [IW:0]      lvl_reg;
    logic [IW:0]      lvl_next;
    logic             stack_full;
    logic [`PC_W-1:0] stk_top;

    // phase sequencer
    always_comb begin
        case (ph_reg)
            PH_FETCH: ph_next = PH_EX2;
            PH_EX2:   ph_next = PH_EX3;
            PH_EX3:   ph_next = PH_EX4;
            PH_EX4:   ph_next = PH_FETCH;
            default:  ph_next = PH_FETCH;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ph_reg    <= PH_FETCH;
            phase_out <= 4'h1;
        end else begin
            ph_reg <= ph_next;
            case (ph_next)
                PH_FETCH: phase_out <= 4'h1;
                PH_EX2:   phase_out <= 4'h2;
                PH_EX3:   phase_out <= 4'h4;
                PH_EX4:   phase_out <= 4'h8;
                default:  phase_out <= 4'h1;
            endcase
        end
    end

    assign end_cyc = (ph_reg == PH_EX4);

    // decode of the instruction in execution
    assign cur_op    = cur_valid_reg ? cur_reg.op : OP_NOP;
    assign cur_fn    = alu_fn_t'(cur_reg.arg[10:7]);
    assign cur_daddr = cur_reg.arg[6:0];
    assign pcl_hit   = (cur_daddr == `PCL_DADDR);
    assign wr_mem    = (cur_op == OP_ALU_M) || (cur_op == OP_SKZ_M && cur_fn != FN_PASS);
    assign wr_acc    = (cur_op == OP_ALU_A) || (cur_op == OP_SKZ_A);
    assign is_jmp    = (cur_op == OP_JMP);
    assign is_call   = (cur_op == OP_CALL);
    assign is_ret    = (cur_op == OP_RET) || (cur_op == OP_INTERRUPT_EXIT);

    // low byte of the counter appears in data memory
    assign opnd = pcl_hit ? pc_reg[7:0] : dmem_rdata_in;

    alu8 u_alu (
        .fn_in     (cur_fn),
        .acc_in    (acc_reg),
        .opnd_in   (opnd),
        .flags_in  (flags_reg),
        .res_out   (alu_res),
        .flags_out (alu_flags)
    );

    // operand read in phase 2, result caught at end of phase 3
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            res_reg       <= 8'h00;
            res_flags_reg <= `FLAGS_RST;
        end else if (ph_reg == PH_EX3) begin
            res_reg       <= alu_res;
            res_flags_reg <= alu_flags;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dmem_req_out <= '0;
        end else begin
            case (ph_reg)
                PH_FETCH: begin
                    dmem_req_out.addr <= cur_daddr;
                    dmem_req_out.we   <= 1'b0;
                end
                PH_EX3: begin
                    dmem_req_out.wdata <= alu_res;
                    dmem_req_out.we    <= wr_mem && !pcl_hit;
                end
                default: dmem_req_out.we <= 1'b0;
            endcase
        end
    end

    // branch decisions
    assign skip_hit = (((cur_op == OP_SKZ_A) || (cur_op == OP_SKZ_M)) && (res_reg == 8'h00))
                    || ((cur_op == OP_SKNZ) && (res_reg != 8'h00));
    assign pcl_jump = (wr_mem && pcl_hit) || pcl_pend_reg;
    assign redirect = is_jmp || is_call || is_ret || pcl_jump;
    assign take_irq = irq_flag_reg && irq_en_in && !stack_full && !redirect && !skip_hit;
    assign flush    = redirect || skip_hit || take_irq;
    assign push     = end_cyc && (is_call || take_irq);
    assign pop      = end_cyc && is_ret;

    always_comb begin
        if (is_jmp || is_call) begin
            pc_next = cur_reg.arg;
        end else if (is_ret) begin
            pc_next = stk_top;
        end else if (pcl_jump) begin
            pc_next = {pc_reg[`PC_W-1:8], (wr_mem && pcl_hit) ? res_reg : pcl_wdata_reg};
        end else if (take_irq) begin
            pc_next = `IRQ_VEC;
        end else begin
            pc_next = `PC_W'(pc_reg + 1'b1);
        end
    end

    // counter and pipeline; the counter always holds the fetch address
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pc_reg        <= `RESET_VEC;
            prog_addr_out <= `RESET_VEC;
            cur_reg       <= instr_t'('0);
            pre_reg       <= instr_t'('0);
            cur_valid_reg <= 1'b0;
        end else begin
            if (ph_reg == PH_EX2) begin
                pre_reg <= prog_word_in;
            end
            if (end_cyc) begin
                pc_reg        <= pc_next;
                prog_addr_out <= pc_next;
                cur_reg       <= pre_reg;
                cur_valid_reg <= !flush;
            end
        end
    end

    // accumulator and status
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            acc_reg   <= `ACC_RST;
            flags_reg <= `FLAGS_RST;
        end else begin
            if (end_cyc && wr_acc) begin
                acc_reg <= res_reg;
            end else if (reg_wr_in && reg_addr_in == `ACC_OFS) begin
                acc_reg <= reg_wdata_in;
            end
            if (end_cyc && (cur_op == OP_ALU_A || cur_op == OP_ALU_M)) begin
                flags_reg <= res_flags_reg;
            end
        end
    end

    // interrupt request latch, a new request beats the acknowledge
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            irq_flag_reg <= 1'b0;
            irq_ack_out  <= 1'b0;
        end else begin
            irq_flag_reg <= irq_in || (irq_flag_reg && !(end_cyc && take_irq));
            irq_ack_out  <= end_cyc && take_irq;
        end
    end

    // return-address stack, circular so an overflow overwrites the oldest
    assign prev_idx   = (top_idx_reg == '0) ? LAST_IDX : top_idx_reg - 1'b1;
    assign stk_top    = stk_mem[prev_idx];
    assign stack_full = (lvl_reg == FULL_LVL);

    always_comb begin
        lvl_next = lvl_reg;
        if (push && !stack_full) begin
            lvl_next = lvl_reg + 1'b1;
        end else if (pop && lvl_reg != '0) begin
            lvl_next = lvl_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            stk_mem[top_idx_reg] <= pc_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            top_idx_reg    <= '0;
            lvl_reg        <= '0;
            stack_full_out <= 1'b0;
        end else begin
            if (push) begin
                top_idx_reg <= (top_idx_reg == LAST_IDX) ? '0 : top_idx_reg + 1'b1;
            end else if (pop) begin
                top_idx_reg <= prev_idx;
            end
            lvl_reg        <= lvl_next;
            stack_full_out <= (lvl_next == FULL_LVL);
        end
    end

    // register port
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pcl_pend_reg  <= 1'b0;
            pcl_wdata_reg <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == `PCL_OFS) begin
            pcl_pend_reg  <= 1'b1;
            pcl_wdata_reg <= reg_wdata_in;
        end else if (end_cyc) begin
            pcl_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PCL_OFS:  reg_rdata_out <= pc_reg[7:0];
                `ACC_OFS:  reg_rdata_out <= acc_reg;
                `STAT_OFS: reg_rdata_out <= {4'h0, flags_reg};
                default:   reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_phase_ring;
        phase_out == 4'h2 ##1 phase_out == 4'h4 ##1 phase_out == 4'h8 ##1 phase_out == 4'h1;
    endsequence

    sequence s_dummy;
        !cur_valid_reg [*4];
    endsequence

    property p_phase_ring;
        phase_out == 4'h1 |=> s_phase_ring;
    endproperty
    a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken");

    property p_fetch_addr;
        phase_out == 4'h1 |-> prog_addr_out == pc_reg;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not counter");

    property p_exec_we;
        dmem_req_out.we |-> phase_out == 4'h8;
    endproperty
    a_exec_we: assert property (p_exec_we) else $error("write outside execute");

    property p_seq_step;
        end_cyc && !flush |=> pc_reg == $past(pc_reg) + 1'b1 && cur_valid_reg;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");

    property p_jump_two;
        end_cyc && is_jmp |=> (pc_reg == $past(cur_reg.arg)) ##0 s_dummy;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_skip;
        end_cyc && skip_hit |=> !cur_valid_reg && pc_reg == $past(pc_reg) + 1'b1;
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not flush");

    property p_pcl_page;
        end_cyc && pcl_jump |=> pc_reg[`PC_W-1:8] == $past(pc_reg[`PC_W-1:8]) && !cur_valid_reg;
    endproperty
    a_pcl_page: assert property (p_pcl_page) else $error("low byte jump left page");

    property p_push;
        push && !stack_full |=> lvl_reg == $past(lvl_reg) + 1'b1;
    endproperty
    a_push: assert property (p_push) else $error("push did not advance level");

    property p_pop;
        pop |=> pc_reg == $past(stk_top);
    endproperty
    a_pop: assert property (p_pop) else $error("return address wrong");

    property p_irq_hold;
        irq_flag_reg && stack_full |-> !take_irq ##1 irq_flag_reg;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt taken on full stack");

    property p_reset;
        disable iff (1'b0)
        !rst_b_in |=> lvl_reg == '0 && pc_reg == `RESET_VEC && !cur_valid_reg;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : core_seq

`default_nettype wire

// *** mem_partner.sv ***
/* program and data memory model facing the core.
   assumes both answer one clock after the address, on clk_in. */
`timescale 1ns/100ps
`default_nettype none
`include "core_regs.svh"
module mem_partner
    import core_pkg::*;
(
    // clock
    input  wire logic             clk_in,
    // program fetch
    input  wire logic [`PC_W-1:0] prog_addr_in,
    output instr_t                prog_word_out,
    // data memory
    input  wire dmem_req_t        dmem_req_in,
    output logic [7:0]            dmem_rdata_out
);
    instr_t     prog [0:2047];
    logic [7:0] data [0:127];

    always_ff @(posedge clk_in) begin
        prog_word_out <= prog[prog_addr_in];
    end

    // loaded by the bench as well
    always @(posedge clk_in) begin
        dmem_rdata_out <= data[dmem_req_in.addr];
        if (dmem_req_in.we) begin
            data[dmem_req_in.addr] <= dmem_req_in.wdata;
        end
    end
endmodule : mem_partner
`default_nettype wire

// *** testbench.sv ***
/* self-checking bench of the sequencing core and its memory model.
   assumes core_pkg, alu8, core_seq and mem_partner are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "core_regs.svh"
module testbench
    import core_pkg::*;
;
    localparam int DEPTH = 2;
    logic        clk_in;
    logic        rst_b_in;
    logic        irq_in;
    logic        irq_en_in;
    logic        irq_ack_out;
    logic        reg_wr_in;
    logic        reg_rd_in;
    logic [3:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic [7:0]  reg_rdata_out;
    logic [3:0]  phase_out;
    logic        stack_full_out;
    logic [10:0] prog_addr;
    instr_t      prog_word;
    dmem_req_t   dmem_req;
    logic [7:0]  dmem_rdata;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [10:0] trace [11] = '{11'h0, 11'h1, 11'h5, 11'h6, 11'h9, 11'ha, 11'h6, 11'h7, 11'h8, 11'h9, 11'h8};

    core_seq #(.STACK_DEPTH(DEPTH)) DUT (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .prog_addr_out(prog_addr), .prog_word_in(prog_word),
        .dmem_req_out(dmem_req), .dmem_rdata_in(dmem_rdata), .irq_in(irq_in), .irq_en_in(irq_en_in),
        .irq_ack_out(irq_ack_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .phase_out(phase_out), .stack_full_out(stack_full_out));
    mem_partner u_mem (.clk_in(clk_in), .prog_addr_in(prog_addr), .prog_word_out(prog_word),
        .dmem_req_in(dmem_req), .dmem_rdata_out(dmem_rdata));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check_val(input string what, input logic [10:0] exp, input logic [10:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : reg_rd

    // program memory back to no-ops while held in reset
    task automatic hold_reset();
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        foreach (u_mem.prog[k]) begin
            u_mem.prog[k] = '0;
        end
    endtask : hold_reset

    task automatic go(input int n);
        repeat (n) @(posedge clk_in);
        rst_b_in <= 1'b1;
    endtask : go

    task automatic wait_addr(input logic [10:0] a);
        for (int i = 0; i < 60 && prog_addr !== a; i++) @(posedge clk_in);
        check_val("fetch address", a, prog_addr);
    endtask : wait_addr

    // result in [7:0], carry (no borrow) in [8]; carry flag starts clear
    function automatic logic [8:0] alu_exp(input alu_fn_t f, input logic [7:0] a, input logic [7:0] m);
        logic [8:0] r;
        case (f)
            FN_ADD, FN_ADC: r = a + m;
            FN_SUB: r = {a >= m, 8'(a - m)};
            FN_SBC: r = {a > m, 8'(a - m - 8'h1)};
            FN_DAA: begin
                r = {1'b0, a};
                if (r[3:0] > 4'h9) r = r + 9'h6;
                if (r[7:4] > 4'h9) r = r + 9'h60;
            end
            FN_AND: r = {1'b0, a & m};
            FN_OR: r = {1'b0, a | m};
            FN_XOR: r = {1'b0, a ^ m};
            FN_CPL: r = {1'b0, ~m};
            FN_RR: r = {1'b0, m[0], m[7:1]};
            FN_RRC: r = {2'b0, m[7:1]};
            FN_RL: r = {1'b0, m[6:0], m[7]};
            FN_RLC: r = {1'b0, m[6:0], 1'b0};
            FN_INC: r = {1'b0, 8'(m + 8'h1)};
            FN_DEC: r = {1'b0, 8'(m - 8'h1)};
            default: r = {1'b0, m};
        endcase
        return r;
    endfunction : alu_exp

    initial begin
        alu_fn_t     f;
        logic [7:0]  a;
        logic [7:0]  m;
        logic [7:0]  d;
        logic [8:0]  e;
        logic [3:0]  ph;
        logic        seen;
        int          n;
        rst_b_in = 1'b0;
        irq_in = 1'b0;
        irq_en_in = 1'b1;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 4'h0;
        reg_wdata_in = 8'h00;
        void'($urandom(68476));
        hold_reset();
        go(5);
        check_val("reset address", `RESET_VEC, prog_addr);
        check_val("reset stack", 11'h0, {10'h0, stack_full_out});
        reg_rd(4'hf, d);
        check_val("unmapped read", 11'h0, {3'h0, d});
        // every function, accumulator then memory destination
        for (int i = 0; i < 32; i++) begin
            f = alu_fn_t'(i[3:0]);
            a = (i == 0) ? 8'hff : 8'($urandom);
            m = (i == 0) ? 8'h01 : 8'($urandom);
            if (i == 2) m = a;
            hold_reset();
            u_mem.prog[0] = '{op: (i < 16) ? OP_ALU_A : OP_ALU_M, arg: {f, 7'h20}};
            u_mem.prog[1] = '{op: OP_JMP, arg: 11'h001};
            u_mem.data[7'h20] = m;
            go(2);
            reg_wr(`ACC_OFS, a);
            repeat (16) @(posedge clk_in);
            e = alu_exp(f, a, m);
            reg_rd(`ACC_OFS, d);
            check_val("accumulator", {3'h0, (i < 16) ? e[7:0] : a}, {3'h0, d});
            check_val("operand", {3'h0, (i < 16) ? m : e[7:0]}, {3'h0, u_mem.data[7'h20]});
            reg_rd(`STAT_OFS, d);
            if (f == FN_ADD || f == FN_SUB) begin
                check_val("flags", {8'h0, e[7:0] == 8'h0, 1'b0, e[8]}, {3'h0, d & 8'h05});
            end
        end
        // jump, call, return, taken skip
        hold_reset();
        u_mem.prog[0] = '{op: OP_JMP, arg: 11'h005};
        u_mem.prog[5] = '{op: OP_CALL, arg: 11'h009};
        u_mem.prog[9] = '{op: OP_RET, arg: 11'h000};
        u_mem.prog[6] = '{op: OP_SKZ_M, arg: {FN_PASS, 7'h21}};
        u_mem.prog[8] = '{op: OP_JMP, arg: 11'h008};
        u_mem.data[7'h21] = 8'h00;
        go(2);
        ph = 4'h8;
        n = 0;
        while (n < 11) begin
            @(posedge clk_in);
            check_val("phase", {7'h0, ph[2:0], ph[3]}, {7'h0, phase_out});
            ph = phase_out;
            if (phase_out === 4'h1) begin
                check_val("trace", trace[n], prog_addr);
                n++;
            end
        end
        // low byte write keeps the page
        hold_reset();
        u_mem.prog[0] = '{op: OP_JMP, arg: 11'h123};
        go(2);
        wait_addr(11'h124);
        reg_wr(`PCL_OFS, 8'h40);
        wait_addr(11'h140);
        reg_rd(`PCL_OFS, d);
        check_val("low byte", 11'h040, {3'h0, d});
        // full stack: call overflows, interrupt waits for a return
        hold_reset();
        u_mem.prog[0] = '{op: OP_CALL, arg: 11'h010};
        u_mem.prog[16] = '{op: OP_CALL, arg: 11'h020};
        u_mem.prog[32] = '{op: OP_CALL, arg: 11'h040};
        u_mem.prog[72] = '{op: OP_RET, arg: 11'h000};
        go(2);
        wait_addr(11'h040);
        check_val("stack full", 11'h1, {10'h0, stack_full_out});
        @(posedge clk_in);
        irq_in <= 1'b1;
        @(posedge clk_in);
        irq_in <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 120 && irq_ack_out !== 1'b1; i++) begin
            @(posedge clk_in);
            if (prog_addr === 11'h021) seen = 1'b1;
        end
        check_val("return first", 11'h1, {10'h0, seen});
        check_val("acknowledge", 11'h1, {10'h0, irq_ack_out});
        check_val("vector", `IRQ_VEC, prog_addr);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
